/* src/ugs_pkg.sv */
// Package of codes, field positions and constants for the general status command block
package ugs_pkg;
  // ----------------------------------------------------------------------
  // Command codes
  // ----------------------------------------------------------------------
  localparam logic [7:0] CMD_RESULT_BASE = 8'hA0;
  localparam logic [7:0] CMD_RESULT_LAST = 8'hAF;
  localparam logic [7:0] CMD_UNLOCK = 8'hB0;
  localparam logic [7:0] CMD_FRAME = 8'hB4;
  localparam logic [7:0] CMD_IDENT = 8'hB5;
  localparam logic [7:0] CMD_EVENTS = 8'hC0;
  localparam logic [15:0] UNLOCK_KEY = 16'hAA37;
  // ----------------------------------------------------------------------
  // Result byte fields
  // ----------------------------------------------------------------------
  localparam int RES_OVERRUN_BIT = 7;
  localparam int RES_TOGGLE_BIT = 6;
  localparam int RES_CODE_LSB = 1;
  localparam int RES_OK_BIT = 0;
  localparam logic [7:0] RESULT_RESET = 8'h00;
  // Result codes
  localparam logic [3:0] RC_NONE = 4'h0;
  localparam logic [3:0] RC_PID_CHECK = 4'h1;
  localparam logic [3:0] RC_PID_UNKNOWN = 4'h2;
  localparam logic [3:0] RC_UNEXPECTED = 4'h3;
  localparam logic [3:0] RC_TOKEN_CRC = 4'h4;
  localparam logic [3:0] RC_DATA_CRC = 4'h5;
  localparam logic [3:0] RC_TIMEOUT = 4'h6;
  localparam logic [3:0] RC_BABBLE = 4'h7;
  localparam logic [3:0] RC_EARLY_END = 4'h8;
  localparam logic [3:0] RC_NAK = 4'h9;
  localparam logic [3:0] RC_STALL = 4'hA;
  localparam logic [3:0] RC_OVERFLOW = 4'hB;
  localparam logic [3:0] RC_EMPTY_ISO = 4'hC;
  localparam logic [3:0] RC_BIT_STUFF = 4'hD;
  localparam logic [3:0] RC_SYNC = 4'hE;
  localparam logic [3:0] RC_BAD_TOGGLE = 4'hF;
  // ----------------------------------------------------------------------
  // Event source register fields
  // ----------------------------------------------------------------------
  localparam int EV_BUS_RESET = 0;
  localparam int EV_RESUME = 1;
  localparam int EV_SLEEP = 2;
  localparam int EV_TRANSFER_END = 3;
  localparam int EV_FRAME = 4;
  localparam int EV_PSEUDO_FRAME = 5;
  localparam int EV_SHORT_END = 6;
  localparam int EV_BUS_SLEEP_STATE = 7;
  localparam int EV_ENDPOINT_LSB = 8;
  localparam int NUM_ENDPOINTS = 16;
  localparam logic [31:0] EVENTS_RESET = 32'h0000_0000;
  localparam logic [31:0] EVENTS_USED = 32'h00FF_FFFF;
  localparam logic [15:0] FRAME_RESET = 16'h0000;
  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CLK_MHZ = 200;
  localparam int PSEUDO_FRAME_US = 1000;
  localparam int PSEUDO_FRAME_CYCLES = PSEUDO_FRAME_US * CLK_MHZ;
  localparam logic [1:0] MISSED_FRAMES_LIMIT = 2'h3;
  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [3:0] endpoint;
    logic [3:0] code;
    logic toggle;
    logic ok;
  } ugs_txn_t;
  typedef enum logic [0:0] {PH_IDLE, PH_DATA} ugs_phase_t;
endpackage

/* src/ugs_general_status.sv */
// General status commands: transaction results, unlock, frame number, identity, event sources
//
// Behaviour
// - Commands A0h..AFh return one result byte for the addressed endpoint.
// - Each new transaction overwrites that endpoint's stored result; no queue.
// - Bit 7 sets when a new event lands before previous result was read.
// - Bit 6 holds data toggle of the last good packet.
// - Bits 4:1 result code, bit 0 transfer ok, bit 5 reserved.
// - Codes 0000..0101: none, PID check, unknown PID, unexpected, token CRC, data CRC.
// - Codes 0110..1111: timeout through wrong toggle, data ignored.
// - Entering suspend blocks all register and FIFO writes until a valid unlock.
// - After resume, reads are refused until a valid unlock.
// - B4h returns 11-bit last frame number, low byte first, one or two bytes.
// - After bus reset the frame number is undefined until a new frame.
// - B5h returns part code high byte, silicon version low byte.
// - Endpoint flags: bits 23..10 endpoints 14..1, 9 control IN, 8 control OUT.
// - Bit 7 shows live bus sleep state; resets to 1 when bus idle.
// - Bit 5 set every 1 ms pseudo tick; three missed frames enter suspend.
// - Bit 4 on frame, bit 3 on counter zero, bit 6 on short-packet end.
// - Bit 2 on awake-to-sleep, bit 1 on resume, bit 0 on bus reset.
// - Command byte with phase select high, data bytes with it low.
// - Counter zero ends a transfer only with count end enable set.
// - Short packet mode makes short or empty OUT packets end a transfer.
module ugs_general_status
  import ugs_pkg::*;
#(
  parameter int FRAME_CYCLES = PSEUDO_FRAME_CYCLES,
  parameter logic [7:0] PART_CODE = 8'h5A,       // Arbitrary value
  parameter logic [7:0] SILICON_VERSION = 8'h01  // Arbitrary value
) (
  input wire logic mclk,                // System clock, 200 MHz
  input wire logic reset_n,             // Synchronous reset, active low
  input wire logic clkEn,               // Freezes all state while low
  input wire logic phaseSelect,         // High: command phase, low: data phase
  input wire logic writeStrobe,         // One-cycle write of dataIn
  input wire logic readStrobe,          // One-cycle read; dataOut is consumed
  input wire logic [7:0] dataIn,        // Write data from host
  output logic [7:0] dataOut,           // Read data, valid before the read strobe
  output logic dataOe,                  // High while a read command is open
  input wire ugs_txn_t txn,             // Transaction outcome from the engine
  input wire logic txnDone,             // Pulse: txn is valid
  input wire logic frameSeen,           // Pulse: start-of-frame received
  input wire logic [10:0] frameNumber,  // Number carried by that frame
  input wire logic busReset,            // Pulse: bus reset detected
  input wire logic resumeSeen,          // Pulse: resume signalling detected
  input wire logic busIdle,             // Bus idle level, caught at reset
  input wire logic dmaCountZero,        // Pulse: DMA byte counter hit zero
  input wire logic dmaShortPacket,      // Pulse: short or empty OUT packet in DMA
  input wire logic count_end_enable,    // DMA configuration bit 15
  input wire logic short_packet_mode,   // DMA configuration bit 14
  input wire logic [31:0] eventEnable,  // Per-flag interrupt enables
  output logic irq,                     // Interrupt request, active high
  output logic writeLock,               // Registers and FIFOs write-protected
  output logic readLock                 // Register reads refused
);
  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  ugs_phase_t phase;
  logic [7:0] command;
  logic [1:0] byteIdx;
  logic [7:0] keyLow;
  logic [7:0] results [NUM_ENDPOINTS];
  logic [NUM_ENDPOINTS-1:0] result_overrun;
  logic [31:0] events;
  logic [31:0] eventSnap;
  logic [10:0] frameCount;
  logic frameValid;
  logic sleeping;
  logic [31:0] tickCount;
  logic [1:0] missed;
  logic frameSinceTick;

  // ----------------------------------------------------------------------
  // Host port decode
  // ----------------------------------------------------------------------
  wire cmdTake = clkEn && writeStrobe && phaseSelect;
  wire dataWrite = clkEn && writeStrobe && !phaseSelect && phase == PH_DATA;
  wire dataRead = clkEn && readStrobe && !phaseSelect && phase == PH_DATA;
  wire [7:0] selCmd = cmdTake ? dataIn : command;
  wire [1:0] selIdx = cmdTake ? 2'h0 : byteIdx + 2'h1;
  wire selIsResult = selCmd[7:4] == CMD_RESULT_BASE[7:4];
  wire selIsRead = selIsResult || selCmd == CMD_FRAME || selCmd == CMD_IDENT
    || selCmd == CMD_EVENTS;
  wire [3:0] selEp = selCmd[3:0];
  wire curIsResult = command[7:4] == CMD_RESULT_BASE[7:4];
  wire [3:0] curEp = command[3:0];
  // Reads while locked return zero and have no side effect
  wire readOk = !readLock;
  wire resultRead = dataRead && curIsResult && readOk;
  // Reading the event register clears it only once the whole word has been read
  wire eventsRead = dataRead && command == CMD_EVENTS && byteIdx == 2'h3 && readOk;
  wire keyHigh = dataWrite && command == CMD_UNLOCK && byteIdx == 2'h1;
  // Unlock is itself a write, so it is held off while the bus still sleeps
  wire unlockOk = keyHigh && !sleeping && {dataIn, keyLow} == UNLOCK_KEY;

  // Read data selection; reserved bits come out as zero
  wire [15:0] frameWord = frameValid ? {5'h00, frameCount} : FRAME_RESET;
  wire [15:0] identWord = {PART_CODE, SILICON_VERSION};
  wire [31:0] eventWord = {8'h00, events[23:8], sleeping, events[6:0]};
  wire [7:0] frameByte = selIdx[0] ? frameWord[15:8] : frameWord[7:0];
  wire [7:0] identByte = selIdx[0] ? identWord[7:0] : identWord[15:8];
  wire [7:0] eventByte = eventWord[8*selIdx +: 8];
  wire [7:0] selByte =
    (selIsResult && selIdx == 2'h0) ? results[selEp] :
    (selCmd == CMD_FRAME && !selIdx[1]) ? frameByte :
    (selCmd == CMD_IDENT && !selIdx[1]) ? identByte :
    (selCmd == CMD_EVENTS) ? eventByte : 8'h00;
  wire [7:0] next_dataOut = readLock ? 8'h00 : selByte;

  // ----------------------------------------------------------------------
  // Command and data phase tracking
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      phase <= PH_IDLE;
      command <= 8'h00;
      byteIdx <= 2'h0;
      dataOut <= 8'h00;
      dataOe <= 1'b0;
    end else if (cmdTake) begin
      phase <= PH_DATA;
      command <= dataIn;
      byteIdx <= 2'h0;
      dataOut <= next_dataOut;
      dataOe <= selIsRead;
    end else if (dataRead || dataWrite) begin
      byteIdx <= byteIdx + 2'h1;   // Wraps after four bytes
      dataOut <= next_dataOut;
    end
  end

  // Low key byte arrives first
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      keyLow <= 8'h00;
    end else if (dataWrite && command == CMD_UNLOCK && byteIdx == 2'h0) begin
      keyLow <= dataIn;
    end
  end

  // ----------------------------------------------------------------------
  // Per-endpoint result store
  // ----------------------------------------------------------------------
  generate
    for (genvar e = 0; e < NUM_ENDPOINTS; e++) begin : g_ep
      wire hit = clkEn && txnDone && txn.endpoint == 4'(e);
      wire readHere = resultRead && curEp == 4'(e) && byteIdx == 2'h0;
      // Toggle only follows good packets; a failed one keeps the old toggle
      wire tog = txn.ok ? txn.toggle : results[e][RES_TOGGLE_BIT];
      always_ff @(posedge mclk) begin
        if (!reset_n) begin
          results[e] <= RESULT_RESET;
          result_overrun[e] <= 1'b0;
        end else if (hit) begin
          // Overwrites in place; bit 5 stays zero
          results[e] <= {result_overrun[e] && !readHere, tog, 1'b0, txn.code, txn.ok};
          result_overrun[e] <= 1'b1;   // New event wins over a read in the same cycle
        end else if (readHere) begin
          results[e][RES_OVERRUN_BIT] <= 1'b0;
          result_overrun[e] <= 1'b0;
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Frame number and pseudo frame tick
  // ----------------------------------------------------------------------
  wire tick = clkEn && tickCount == 32'(FRAME_CYCLES - 1);
  wire missTick = tick && !frameSinceTick && !(clkEn && frameSeen);
  wire goSleep = missTick && missed == MISSED_FRAMES_LIMIT - 2'h1 && !sleeping;
  wire wake = clkEn && (resumeSeen || frameSeen || busReset);

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      frameCount <= 11'h000;
      frameValid <= 1'b0;
    end else if (clkEn && frameSeen) begin
      frameCount <= frameNumber;
      frameValid <= 1'b1;
    end else if (clkEn && busReset) begin
      frameValid <= 1'b0;
    end
  end

  // Tick keeps running while asleep so a missing bus is still noticed
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      tickCount <= 32'h0000_0000;
      missed <= 2'h0;
      frameSinceTick <= 1'b0;
    end else if (clkEn) begin
      tickCount <= tick ? 32'h0000_0000 : tickCount + 32'h0000_0001;
      // Any wake restarts the count, or a resumed bus could never sleep again
      if (frameSeen || busReset || resumeSeen) begin
        missed <= 2'h0;
      end else if (missTick && missed != MISSED_FRAMES_LIMIT) begin
        missed <= missed + 2'h1;
      end
      frameSinceTick <= tick ? 1'b0 : (frameSinceTick || frameSeen);
    end
  end

  // ----------------------------------------------------------------------
  // Suspend state and access locks
  // ----------------------------------------------------------------------
  // A synchronous reset may sample the idle level directly
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      sleeping <= busIdle;
      writeLock <= 1'b0;
      readLock <= 1'b0;
    end else if (clkEn) begin
      if (goSleep) begin
        sleeping <= 1'b1;
      end else if (wake) begin
        sleeping <= 1'b0;
      end
      if (goSleep) begin
        writeLock <= 1'b1;
      end else if (unlockOk) begin
        writeLock <= 1'b0;
      end
      if (sleeping && resumeSeen) begin
        readLock <= 1'b1;
      end else if (unlockOk) begin
        readLock <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Event source flags
  // ----------------------------------------------------------------------
  logic [31:0] evSet;
  logic [31:0] evClr;
  always_comb begin
    evSet = 32'h0000_0000;
    evSet[EV_BUS_RESET] = busReset;
    evSet[EV_RESUME] = resumeSeen;
    evSet[EV_SLEEP] = goSleep;
    evSet[EV_TRANSFER_END] = dmaCountZero && count_end_enable;
    evSet[EV_FRAME] = frameSeen;
    evSet[EV_PSEUDO_FRAME] = tick;
    evSet[EV_SHORT_END] = dmaShortPacket && short_packet_mode;
    if (txnDone) begin
      evSet[EV_ENDPOINT_LSB + 32'(txn.endpoint)] = 1'b1;
    end
    evSet = clkEn ? evSet : 32'h0000_0000;
    evClr = eventsRead ? eventSnap : 32'h0000_0000;
    if (resultRead && byteIdx == 2'h0) begin
      evClr[EV_ENDPOINT_LSB + 32'(curEp)] = 1'b1;
    end
  end

  // An events read clears only flags captured when its command was taken; a result read clears its endpoint flag; sets always win
  wire [31:0] next_events = ((events & ~evClr) | evSet) & EVENTS_USED;
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      events <= EVENTS_RESET;
      eventSnap <= EVENTS_RESET;
      irq <= 1'b0;
    end else if (clkEn) begin
      events <= next_events;
      if (cmdTake && dataIn == CMD_EVENTS) begin
        eventSnap <= events;
      end
      irq <= |(next_events & eventEnable & ~(32'h1 << EV_BUS_SLEEP_STATE));
    end
  end
endmodule

/* verif/ugs_monitor.sv */
// Port checker for the general status command block
module ugs_monitor
  import ugs_pkg::*;
#(
  parameter logic [7:0] PART_CODE = 8'h5A  // Arbitrary value
) (
  input wire logic mclk,                // System clock
  input wire logic reset_n,             // Synchronous reset, active low
  input wire logic clkEn,               // Clock enable
  input wire logic phaseSelect,         // Command or data phase
  input wire logic writeStrobe,         // Write strobe
  input wire logic [7:0] dataIn,        // Write data
  input wire logic [7:0] dataOut,       // Read data
  input wire logic dataOe,              // Read command open
  input wire ugs_txn_t txn,             // Transaction outcome
  input wire logic txnDone,             // Outcome valid
  input wire logic frameSeen,           // Frame received
  input wire logic [10:0] frameNumber,  // Frame number
  input wire logic busReset,            // Bus reset
  input wire logic resumeSeen,          // Resume seen
  input wire logic [31:0] eventEnable,  // Interrupt enables
  input wire logic irq,                 // Interrupt request
  input wire logic writeLock,           // Write protection
  input wire logic readLock             // Read protection
);
  // ----------------------------------------------------------------------
  // Decodes and the frame number a read must return
  // ----------------------------------------------------------------------
  logic [10:0] lastFrame;
  wire cmdTaken = clkEn && writeStrobe && phaseSelect;
  wire resultCmd = cmdTaken && dataIn[7:4] == 4'hA;
  wire readCmd = resultCmd || (cmdTaken && (dataIn == CMD_FRAME || dataIn == CMD_IDENT
    || dataIn == CMD_EVENTS));
  // Bus reset leaves the number undefined; the design settles it to zero
  // A frame in the same cycle as a bus reset still counts, as in the design
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      lastFrame <= 11'h000;
    end else if (clkEn && frameSeen) begin
      lastFrame <= frameNumber;
    end else if (clkEn && busReset) begin
      lastFrame <= 11'h000;
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  // ----------------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------------
  property p_cmd_opens; readCmd |=> dataOe; endproperty
  a_cmd_opens: assert property (p_cmd_opens) else $error("no output enable after read");
  property p_frame_low; cmdTaken && dataIn == CMD_FRAME && !readLock |=> dataOut == lastFrame[7:0];
  endproperty
  a_frame_low: assert property (p_frame_low) else $error("frame low byte wrong");
  property p_ident; cmdTaken && dataIn == CMD_IDENT && !readLock |=> dataOut == PART_CODE; endproperty
  a_ident: assert property (p_ident) else $error("part code wrong");
  property p_locked_read; readCmd && readLock |=> dataOut == 8'h00; endproperty
  a_locked_read: assert property (p_locked_read) else $error("locked read returned data");
  property p_result;
    clkEn && txnDone && txn.ok ##1 (resultCmd && !readLock && dataIn[3:0] == $past(txn.endpoint))
    |=> dataOut[6:0] == {$past(txn.toggle, 2), 1'b0, $past(txn.code, 2), 1'b1};
  endproperty
  a_result: assert property (p_result) else $error("result byte wrong");
  property p_result_reserved; resultCmd && !readLock |=> !dataOut[5]; endproperty
  a_result_reserved: assert property (p_result_reserved) else $error("reserved bit set");
  property p_irq_set; clkEn && txnDone && eventEnable[EV_ENDPOINT_LSB + txn.endpoint] |=> irq;
  endproperty
  a_irq_set: assert property (p_irq_set) else $error("enabled flag without interrupt");
  property p_irq_quiet; $past(clkEn) && $past(eventEnable) == 32'h0000_0000 |-> !irq; endproperty
  a_irq_quiet: assert property (p_irq_quiet) else $error("interrupt with no enable");
  property p_read_lock_cause; $rose(readLock) |-> $past(resumeSeen); endproperty
  a_read_lock_cause: assert property (p_read_lock_cause) else $error("read lock without resume");
  property p_unlock_key;
    $fell(writeLock) || $fell(readLock) |-> $past(writeStrobe) && !$past(phaseSelect)
      && $past(dataIn) == UNLOCK_KEY[15:8];
  endproperty
  a_unlock_key: assert property (p_unlock_key) else $error("lock dropped without key");
  c_frame_read: cover property (cmdTaken && dataIn == CMD_FRAME);
  c_sleep: cover property ($rose(writeLock));
  c_locked_read: cover property (readCmd && readLock);
  c_irq: cover property ($rose(irq));
endmodule

bind ugs_general_status ugs_monitor #(.PART_CODE(PART_CODE)) ugs_monitor_i (
  .mclk(mclk), .reset_n(reset_n), .clkEn(clkEn), .phaseSelect(phaseSelect),
  .writeStrobe(writeStrobe), .dataIn(dataIn), .dataOut(dataOut), .dataOe(dataOe), .txn(txn),
  .txnDone(txnDone), .frameSeen(frameSeen), .frameNumber(frameNumber), .busReset(busReset),
  .resumeSeen(resumeSeen), .eventEnable(eventEnable), .irq(irq), .writeLock(writeLock),
  .readLock(readLock)
);

/* verif/ugs_host_model.sv */
// Host controller model for the command and data phases of the parallel port
module ugs_host_model
  import ugs_pkg::*;
(
  input wire logic mclk,           // System clock
  input wire logic [7:0] dataOut,  // Read data from the block
  output logic phaseSelect,        // Command or data phase
  output logic writeStrobe,        // Write strobe
  output logic readStrobe,         // Read strobe
  output logic [7:0] dataIn        // Write data
);
  // ----------------------------------------------------------------------
  // Bus cycles; each starts and ends just after an edge with an idle cycle,
  // so a strobe is never lowered and raised in one time step
  // ----------------------------------------------------------------------
  initial begin
    phaseSelect = 1'b1;
    writeStrobe = 1'b0;
    readStrobe = 1'b0;
    dataIn = 8'h00;
  end
  task automatic put(input logic ph, input logic [7:0] d);
    phaseSelect = ph;
    dataIn = d;
    writeStrobe = 1'b1;
    @(posedge mclk);
    #1;
    writeStrobe = 1'b0;
    dataIn = ~d;  // Released bus never shows the last byte
    @(posedge mclk);
    #1;
  endtask
  task automatic get(output logic [7:0] v);
    phaseSelect = 1'b0;
    v = dataOut;
    readStrobe = 1'b1;
    @(posedge mclk);
    #1;
    readStrobe = 1'b0;
    @(posedge mclk);
    #1;
  endtask
  // Event sources are always read whole, or the flags would never clear
  task automatic read_events(output logic [31:0] v);
    logic [7:0] b;
    put(1'b1, CMD_EVENTS);
    for (int i = 0; i < 4; i++) begin
      get(b);
      v[8*i +: 8] = b;
    end
  endtask
  task automatic unlock();
    put(1'b1, CMD_UNLOCK);
    put(1'b0, UNLOCK_KEY[7:0]);
    put(1'b0, UNLOCK_KEY[15:8]);
  endtask
endmodule

/* verif/test_usb_device_general_status.sv */
// Self-checking bench of the general status command block
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin n_fail++; \
  $display("wrong value at %0t ns: got %h expected %h", $time, got, exp); end end
module test_usb_device_general_status
  import ugs_pkg::*;
();
  timeunit 1ns;
  timeprecision 100ps;
  localparam int FRAME_CYCLES = 1000;  // Short tick so sleep comes within the wait bound
  localparam logic [7:0] PART_CODE = 8'h3C;  // Arbitrary value
  localparam logic [7:0] SILICON_VERSION = 8'h07;  // Arbitrary value
  logic mclk = 1'b0, reset_n = 1'b0, clkEn = 1'b1, busIdle = 1'b1, txnDone = 1'b0;
  logic frameSeen = 1'b0, busReset = 1'b0, resumeSeen = 1'b0, dmaCountZero = 1'b0;
  logic dmaShortPacket = 1'b0, count_end_enable = 1'b0, short_packet_mode = 1'b0;
  logic phaseSelect, writeStrobe, readStrobe, dataOe, irq, writeLock, readLock;
  logic [7:0] dataIn, dataOut;
  logic [10:0] frameNumber = 11'h000;
  logic [31:0] eventEnable = 32'h0000_0000;
  ugs_txn_t txn = '0;
  int n_fail = 0, tests_run = 0;
  always #2.5 mclk = ~mclk;
  ugs_general_status #(.FRAME_CYCLES(FRAME_CYCLES), .PART_CODE(PART_CODE),
    .SILICON_VERSION(SILICON_VERSION)) ugs_general_status_i (.mclk(mclk), .reset_n(reset_n),
    .clkEn(clkEn), .phaseSelect(phaseSelect), .writeStrobe(writeStrobe), .readStrobe(readStrobe),
    .dataIn(dataIn), .dataOut(dataOut), .dataOe(dataOe), .txn(txn), .txnDone(txnDone),
    .frameSeen(frameSeen), .frameNumber(frameNumber), .busReset(busReset),
    .resumeSeen(resumeSeen), .busIdle(busIdle), .dmaCountZero(dmaCountZero),
    .dmaShortPacket(dmaShortPacket), .count_end_enable(count_end_enable),
    .short_packet_mode(short_packet_mode), .eventEnable(eventEnable), .irq(irq),
    .writeLock(writeLock), .readLock(readLock));
  ugs_host_model ugs_host_model_i (.mclk(mclk), .dataOut(dataOut), .phaseSelect(phaseSelect),
    .writeStrobe(writeStrobe), .readStrobe(readStrobe), .dataIn(dataIn));
  // ----------------------------------------------------------------------
  // Helpers; all start and end just after a rising edge
  // ----------------------------------------------------------------------
  task automatic pulse(ref logic s);
    s = 1'b1;
    @(posedge mclk);
    #1;
    s = 1'b0;
  endtask
  task automatic post(input logic [3:0] ep, input logic [3:0] rc, input logic tg, input logic ok);
    txn = '{ep, rc, tg, ok};
    pulse(txnDone);
  endtask
  task automatic cmd(input logic [7:0] c);
    ugs_host_model_i.put(1'b1, c);
  endtask
  task automatic expect_byte(input logic [7:0] e);
    logic [7:0] v;
    ugs_host_model_i.get(v);
    `CHK(v, e)
  endtask
  task automatic expect_events(input logic [31:0] e);
    logic [31:0] v;
    ugs_host_model_i.read_events(v);
    `CHK(v, e)
  endtask
  task automatic end_test(input string name);
    $display("test %s ended, mismatches so far %0d", name, n_fail);
  endtask
  task automatic test_done();
    $display("comparisons %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    repeat (16) @(posedge mclk);
    #1;
    reset_n = 1'b1;
    expect_events(32'h0000_0080);
    cmd(CMD_IDENT);
    `CHK(dataOe, 1'b1)
    expect_byte(PART_CODE);
    expect_byte(SILICON_VERSION);
    cmd(CMD_RESULT_BASE + 8'h3);
    expect_byte(RESULT_RESET);
    end_test("reset and identity");
    frameNumber = 11'h5A3;
    pulse(frameSeen);
    cmd(CMD_FRAME);
    expect_byte(8'hA3);
    expect_byte(8'h05);
    pulse(busReset);
    cmd(CMD_FRAME);
    expect_byte(FRAME_RESET[7:0]);
    expect_events(32'h0000_0011);
    end_test("frame number");
    // Every code on its own endpoint; toggle only follows good packets
    for (int i = 0; i < 16; i++) begin
      post(i[3:0], i[3:0], 1'b1, i[0]);
      cmd(CMD_RESULT_BASE + 8'(i));
      expect_byte({1'b0, i[0], 1'b0, i[3:0], i[0]});
    end
    `CHK(irq, 1'b0)
    eventEnable = 32'h0000_2000;
    post(4'h5, RC_NAK, 1'b0, 1'b0);
    @(posedge mclk);
    #1;
    `CHK(irq, 1'b1)
    post(4'h5, RC_STALL, 1'b0, 1'b0);
    expect_events(32'h0000_2000);
    cmd(CMD_RESULT_BASE + 8'h5);
    expect_byte({1'b1, 1'b1, 1'b0, RC_STALL, 1'b0});
    `CHK(irq, 1'b0)
    end_test("results");
    eventEnable = 32'h0000_0000;
    pulse(dmaCountZero);
    count_end_enable = 1'b1;
    pulse(dmaCountZero);
    pulse(dmaShortPacket);
    short_packet_mode = 1'b1;
    pulse(dmaShortPacket);
    expect_events(32'h0000_0048);
    end_test("transfer end");
    for (int i = 0; i < 5000 && writeLock !== 1'b1; i++) begin
      @(posedge mclk);
    end
    #1;
    `CHK(writeLock, 1'b1)
    if (writeLock !== 1'b1) begin
      test_done();
    end
    expect_events(32'h0000_00A4);
    ugs_host_model_i.unlock();
    `CHK(writeLock, 1'b1)
    pulse(resumeSeen);
    @(posedge mclk);
    #1;
    `CHK(readLock, 1'b1)
    cmd(CMD_IDENT);
    expect_byte(8'h00);
    ugs_host_model_i.unlock();
    `CHK({writeLock, readLock}, 2'b00)
    `CHK(dataOe, 1'b0)
    cmd(CMD_IDENT);
    expect_byte(PART_CODE);
    expect_events(32'h0000_0002);
    end_test("sleep and unlock");
    // Reset in mid-run with an active bus, then a bus reset while frozen
    reset_n = 1'b0;
    busIdle = 1'b0;
    repeat (2) @(posedge mclk);
    #1;
    reset_n = 1'b1;
    clkEn = 1'b0;
    pulse(busReset);
    clkEn = 1'b1;
    expect_events(EVENTS_RESET);
    end_test("reset and freeze");
    test_done();
  end
endmodule
